// file: verilog/ltp_map.svh
/*
  register offsets, field positions, reset values and divider counts of the
  legacy timer pair.
  assumes: included by its bare name; definitions only.
*/
`ifndef LTP_MAP_SVH
`define LTP_MAP_SVH

// register indices; byte address on the bus is four times the index
`define LTP_IDX_RUN_FLAG 8'h88
`define LTP_IDX_MODE 8'h89
`define LTP_IDX_CNT_A_LOW 8'h8A
`define LTP_IDX_CNT_B_LOW 8'h8B
`define LTP_IDX_CNT_A_HIGH 8'h8C
`define LTP_IDX_CNT_B_HIGH 8'h8D
`define LTP_IDX_CLOCK_SEL 8'h8E
`define LTP_IDX_EXT_CFG 8'h8F
`define LTP_IDX_INT_EN 8'h90
`define LTP_IDX_IRQ_STATUS 8'h91
`define LTP_IDX_IRQ_MASK 8'h92

// reset values
`define LTP_RST_BYTE 8'h00

// timer_run_flag_reg fields
`define LTP_RUN_FLAG_OVF_B 7
`define LTP_RUN_FLAG_RUN_B 6
`define LTP_RUN_FLAG_OVF_A 5
`define LTP_RUN_FLAG_RUN_A 4
`define LTP_RUN_FLAG_MASK 8'hF0

// timer_mode_reg fields, per timer the nibble starts at 4*i
`define LTP_MODE_GATE 3
`define LTP_MODE_CTSEL 2
`define LTP_MODE_FIELD_LSB 0

// timer_clock_select fields
`define LTP_CKSEL_RELOAD_B_HIGH 7
`define LTP_CKSEL_RELOAD_B_LOW 6
`define LTP_CKSEL_RELOAD_A_HIGH 5
`define LTP_CKSEL_RELOAD_A_LOW 4
`define LTP_CKSEL_TIMER_B 3
`define LTP_CKSEL_TIMER_A 2
`define LTP_CKSEL_PRESCALE_LSB 0

// ext_input_config and interrupt_enables fields
`define LTP_EXT_POL_A 3
`define LTP_EXT_POL_B 7
`define LTP_IE_OVF_A 1
`define LTP_IE_OVF_B 3

// irq status and mask layout
`define LTP_IRQ_OVF_A 0
`define LTP_IRQ_OVF_B 1
`define LTP_IRQ_MASK 8'h03

// prescaler terminal counts (divisor minus one)
`define LTP_DIV12_LAST 6'h0B
`define LTP_DIV4_LAST 6'h03
`define LTP_DIV48_LAST 6'h2F
`define LTP_EXT_DIV8_LAST 6'h07

// 13-bit count wrap point
`define LTP_CNT13_ALL_ONES 13'h1FFF

`endif

// file: verilog/ltp_pkg.sv
/*
  types of the legacy timer pair.
  assumes: compiled before every module of the block.
*/
package ltp_pkg;

  // timer operating modes as decoded from the two-bit mode field
  typedef enum logic [1:0] {
    LTP_MODE_13BIT,
    LTP_MODE_16BIT,
    LTP_MODE_8BIT_RELOAD,
    LTP_MODE_SPLIT
  } ltp_mode_t;

  // prescaler source choice
  typedef enum logic [1:0] {
    LTP_PRE_DIV12,
    LTP_PRE_DIV4,
    LTP_PRE_DIV48,
    LTP_PRE_EXT_DIV8
  } ltp_pre_t;

  // bus slave handshake
  typedef enum logic {
    LTP_BUS_IDLE,
    LTP_BUS_DONE
  } ltp_bus_t;

endpackage

// file: verilog/ltp_fall_detect.sv
/*
  two-flop synchroniser with falling edge detection.
  assumes: pin_in may be asynchronous; fall_q is a one-cycle pulse on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module ltp_fall_detect
  import ltp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin_in,
  output logic fall_q
);

  logic sync1_q, sync1_d;
  logic sync2_q, sync2_d;
  logic prev_q, prev_d;
  logic fall_d;

  // the first flop feeds only the second; edges are seen on settled levels
  always_comb
  begin
    sync1_d = pin_in;
    sync2_d = sync1_q;
    prev_d = sync2_q;
    fall_d = prev_q & ~sync2_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
      fall_q <= 1'b0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      fall_q <= fall_d;
    end
  end

endmodule

`default_nettype wire

// file: verilog/ltp_prescaler.sv
/*
  shared prescaler: one-cycle tick at sysclk/12, /4, /48 or ext clock/8.
  assumes: ext_fall is a synchronised one-cycle edge pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ltp_map.svh"

module ltp_prescaler
  import ltp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [1:0] prescale_field,
  input wire logic ext_fall,
  output logic tick_q
);

  logic [5:0] div_q, div_d;
  logic tick_d;
  logic [5:0] last;
  logic step;

  // a change of field mid-count alters only one period; a count at or past the new last ticks at the next step
  always_comb
  begin
    case (ltp_pre_t'(prescale_field))
      LTP_PRE_DIV12: last = `LTP_DIV12_LAST;
      LTP_PRE_DIV4: last = `LTP_DIV4_LAST;
      LTP_PRE_DIV48: last = `LTP_DIV48_LAST;
      LTP_PRE_EXT_DIV8: last = `LTP_EXT_DIV8_LAST;
      default: last = `LTP_DIV12_LAST;
    endcase
    step = (ltp_pre_t'(prescale_field) == LTP_PRE_EXT_DIV8) ? ext_fall : 1'b1;
    div_d = div_q;
    tick_d = 1'b0;
    if (step)
    begin
      if (div_q >= last)
      begin
        div_d = 6'h00;
        tick_d = 1'b1;
      end
      else
      begin
        div_d = div_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      div_q <= 6'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

endmodule

`default_nettype wire

// file: verilog/ltp_timer_pair.sv
/*
  legacy timer pair in 13-bit mode with clock selection, gating, overflow
  flags, sticky irq status and an avalon-mm register slave.
  assumes: one clock clk_sys at 250 MHz, synchronous active-high reset;
  gate inputs are synchronous; count pins may be asynchronous.
*/
// Added by the designer: the Avalon-MM interface to the registers.
// What this block does
// - counter mode counts falling edges of count pin
// - prescale field picks /12, /4, /48, ext/8
// - bit 3 picks timer b timebase
// - bit 2 picks timer a timebase
// - bits 4,5 pick reload timer a clocks
// - bits 6,7 pick reload timer b clocks
// - each count is two byte registers
// - high byte msbs, low bits 4:0 lsbs
// - wrap from all ones sets overflow flag
// - count only when run and gate allow
// - setting run leaves count unchanged
// - timer b uses the same logic as timer a
// - timers configured independently
// - overflow irq passed only when enabled
// - mode field decodes four modes; only 13-bit mode counts here, the other three hold the count
// - flag set by hardware, cleared by software or vector
`timescale 1ns/1ps
`default_nettype none
`include "ltp_map.svh"

module ltp_timer_pair
  import ltp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic count_pin_a,
  input wire logic count_pin_b,
  input wire logic ext_clock_pin,
  input wire logic gate_input_a,
  input wire logic gate_input_b,
  input wire logic vector_ack_a,
  input wire logic vector_ack_b,
  output logic overflow_irq_a,
  output logic overflow_irq_b,
  output logic irq,
  output logic reload_a_low_clock_sel,
  output logic reload_a_high_clock_sel,
  output logic reload_b_low_clock_sel,
  output logic reload_b_high_clock_sel
);

  // register state
  logic [7:0] clock_sel_q, clock_sel_d;
  logic [7:0] run_flag_q, run_flag_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] ext_cfg_q, ext_cfg_d;
  logic [7:0] int_en_q, int_en_d;
  logic [7:0] sts_q, sts_d;
  logic [7:0] msk_q, msk_d;
  logic [7:0] cnt_low_q [2];
  logic [7:0] cnt_low_d [2];
  logic [7:0] cnt_high_q [2];
  logic [7:0] cnt_high_d [2];
  ltp_bus_t bus_q, bus_d;
  logic [31:0] rdata_d;
  logic [1:0] ovf_irq_d;
  logic irq_d;

  // per-timer helper nets
  logic [1:0] pin_fall;
  logic [1:0] tick;
  logic [1:0] count_en;
  logic [1:0] wrap;
  logic [1:0] pin_in;
  logic [1:0] gate_in;
  logic [1:0] ack_in;
  logic pre_tick;
  logic ext_fall;

  // bus decode
  logic access;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic [7:0] wbyte;

  assign pin_in = {count_pin_b, count_pin_a};
  assign gate_in = {gate_input_b, gate_input_a};
  assign ack_in = {vector_ack_b, vector_ack_a};

  // field positions per timer, decoded in several places
  function automatic int run_pos(input int i);
    run_pos = (i == 0) ? `LTP_RUN_FLAG_RUN_A : `LTP_RUN_FLAG_RUN_B;
  endfunction

  function automatic int ovf_pos(input int i);
    ovf_pos = (i == 0) ? `LTP_RUN_FLAG_OVF_A : `LTP_RUN_FLAG_OVF_B;
  endfunction

  function automatic logic [7:0] low_idx(input int i);
    low_idx = (i == 0) ? `LTP_IDX_CNT_A_LOW : `LTP_IDX_CNT_B_LOW;
  endfunction

  function automatic logic [7:0] high_idx(input int i);
    high_idx = (i == 0) ? `LTP_IDX_CNT_A_HIGH : `LTP_IDX_CNT_B_HIGH;
  endfunction

  // external clock for the prescaler passes the same synchroniser
  ltp_fall_detect u_ext_fall (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(ext_clock_pin),
    .fall_q(ext_fall)
  );

  ltp_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .reset(reset),
    .prescale_field(clock_sel_q[`LTP_CKSEL_PRESCALE_LSB +: 2]),
    .ext_fall(ext_fall),
    .tick_q(pre_tick)
  );

  // one timebase, gate and wrap path per timer; both have their own settings
  for (genvar g = 0; g < 2; g++)
  begin : g_timer
    logic [3:0] nib;
    logic gate_ok;
    logic [12:0] cnt13;
    logic cksel;
    logic pol;

    assign nib = mode_q[4*g +: 4];
    assign cksel = clock_sel_q[(g == 0) ? `LTP_CKSEL_TIMER_A : `LTP_CKSEL_TIMER_B];
    assign pol = ext_cfg_q[(g == 0) ? `LTP_EXT_POL_A : `LTP_EXT_POL_B];

    ltp_fall_detect u_pin_fall (
      .clk_sys(clk_sys),
      .reset(reset),
      .pin_in(pin_in[g]),
      .fall_q(pin_fall[g])
    );

    // counter mode ignores the clock-select bit
    assign tick[g] = nib[`LTP_MODE_CTSEL] ? pin_fall[g] :
      (cksel ? 1'b1 : pre_tick);
    assign gate_ok = ~nib[`LTP_MODE_GATE] | (gate_in[g] == pol);
    // only the 13-bit mode counts here; the other modes hold the count
    assign count_en[g] = run_flag_q[run_pos(g)] & gate_ok & tick[g] &
      (ltp_mode_t'(nib[`LTP_MODE_FIELD_LSB +: 2]) == LTP_MODE_13BIT);
    assign cnt13 = {cnt_high_q[g], cnt_low_q[g][4:0]};
    assign wrap[g] = count_en[g] & (cnt13 == `LTP_CNT13_ALL_ONES);
  end

  assign access = (avs_read | avs_write) & (bus_q == LTP_BUS_IDLE);
  assign wr_en = access & avs_write & avs_byteenable[0];
  assign rd_en = access & avs_read;
  assign idx = avs_address[9:2];
  assign wbyte = avs_writedata[7:0];

  // register next values: bus writes, counting, flags and read data
  always_comb
  begin
    logic [12:0] nxt13;
    nxt13 = 13'h0000;
    clock_sel_d = clock_sel_q;
    run_flag_d = run_flag_q;
    mode_d = mode_q;
    ext_cfg_d = ext_cfg_q;
    int_en_d = int_en_q;
    sts_d = sts_q;
    msk_d = msk_q;
    bus_d = access ? LTP_BUS_DONE : LTP_BUS_IDLE;
    rdata_d = 32'h0000_0000;
    for (int i = 0; i < 2; i++)
    begin
      cnt_low_d[i] = cnt_low_q[i];
      cnt_high_d[i] = cnt_high_q[i];
      // count first, so a software byte write on the same edge wins
      if (count_en[i])
      begin
        nxt13 = {cnt_high_q[i], cnt_low_q[i][4:0]} + 13'h0001;
        cnt_high_d[i] = nxt13[12:5];
        cnt_low_d[i] = {cnt_low_q[i][7:5], nxt13[4:0]};
      end
    end
    // writes to unmapped indices are dropped; reads of them return zero
    if (wr_en)
    begin
      case (idx)
        `LTP_IDX_CLOCK_SEL: clock_sel_d = wbyte;
        `LTP_IDX_RUN_FLAG: run_flag_d = wbyte & `LTP_RUN_FLAG_MASK;
        `LTP_IDX_MODE: mode_d = wbyte;
        `LTP_IDX_EXT_CFG: ext_cfg_d = wbyte;
        `LTP_IDX_INT_EN: int_en_d = wbyte;
        `LTP_IDX_IRQ_MASK: msk_d = wbyte & `LTP_IRQ_MASK;
        default: ;
      endcase
      for (int i = 0; i < 2; i++)
      begin
        if (idx == low_idx(i))
        begin
          cnt_low_d[i] = wbyte;
        end
        if (idx == high_idx(i))
        begin
          cnt_high_d[i] = wbyte;
        end
      end
    end
    if (rd_en)
    begin
      case (idx)
        `LTP_IDX_CLOCK_SEL: rdata_d[7:0] = clock_sel_q;
        `LTP_IDX_RUN_FLAG: rdata_d[7:0] = run_flag_q;
        `LTP_IDX_MODE: rdata_d[7:0] = mode_q;
        `LTP_IDX_EXT_CFG: rdata_d[7:0] = ext_cfg_q;
        `LTP_IDX_INT_EN: rdata_d[7:0] = int_en_q;
        `LTP_IDX_IRQ_STATUS: rdata_d[7:0] = sts_q;
        `LTP_IDX_IRQ_MASK: rdata_d[7:0] = msk_q;
        default: rdata_d = 32'h0000_0000;
      endcase
      for (int i = 0; i < 2; i++)
      begin
        if (idx == low_idx(i))
        begin
          rdata_d[7:0] = cnt_low_q[i];
        end
        if (idx == high_idx(i))
        begin
          rdata_d[7:0] = cnt_high_q[i];
        end
      end
      if (idx == `LTP_IDX_IRQ_STATUS)
      begin
        sts_d = 8'h00;
      end
    end
    // flag clears first, then hardware sets so an event on the clear edge stays
    for (int i = 0; i < 2; i++)
    begin
      if (ack_in[i])
      begin
        run_flag_d[ovf_pos(i)] = 1'b0;
      end
      if (wrap[i])
      begin
        run_flag_d[ovf_pos(i)] = 1'b1;
        sts_d[(i == 0) ? `LTP_IRQ_OVF_A : `LTP_IRQ_OVF_B] = 1'b1;
      end
    end
    ovf_irq_d[0] = run_flag_d[`LTP_RUN_FLAG_OVF_A] & int_en_d[`LTP_IE_OVF_A];
    ovf_irq_d[1] = run_flag_d[`LTP_RUN_FLAG_OVF_B] & int_en_d[`LTP_IE_OVF_B];
    irq_d = |(sts_d & msk_d);
  end

  // registers and every top-level output
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      clock_sel_q <= `LTP_RST_BYTE;
      run_flag_q <= `LTP_RST_BYTE;
      mode_q <= `LTP_RST_BYTE;
      ext_cfg_q <= `LTP_RST_BYTE;
      int_en_q <= `LTP_RST_BYTE;
      sts_q <= `LTP_RST_BYTE;
      msk_q <= `LTP_RST_BYTE;
      for (int i = 0; i < 2; i++)
      begin
        cnt_low_q[i] <= `LTP_RST_BYTE;
        cnt_high_q[i] <= `LTP_RST_BYTE;
      end
      bus_q <= LTP_BUS_IDLE;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      overflow_irq_a <= 1'b0;
      overflow_irq_b <= 1'b0;
      irq <= 1'b0;
      reload_a_low_clock_sel <= 1'b0;
      reload_a_high_clock_sel <= 1'b0;
      reload_b_low_clock_sel <= 1'b0;
      reload_b_high_clock_sel <= 1'b0;
    end
    else
    begin
      clock_sel_q <= clock_sel_d;
      run_flag_q <= run_flag_d;
      mode_q <= mode_d;
      ext_cfg_q <= ext_cfg_d;
      int_en_q <= int_en_d;
      sts_q <= sts_d;
      msk_q <= msk_d;
      for (int i = 0; i < 2; i++)
      begin
        cnt_low_q[i] <= cnt_low_d[i];
        cnt_high_q[i] <= cnt_high_d[i];
      end
      bus_q <= bus_d;
      avs_readdata <= rdata_d;
      avs_waitrequest <= ~access; // low for one cycle after the capture edge
      overflow_irq_a <= ovf_irq_d[0];
      overflow_irq_b <= ovf_irq_d[1];
      irq <= irq_d;
      reload_a_low_clock_sel <= clock_sel_d[`LTP_CKSEL_RELOAD_A_LOW];
      reload_a_high_clock_sel <= clock_sel_d[`LTP_CKSEL_RELOAD_A_HIGH];
      reload_b_low_clock_sel <= clock_sel_d[`LTP_CKSEL_RELOAD_B_LOW];
      reload_b_high_clock_sel <= clock_sel_d[`LTP_CKSEL_RELOAD_B_HIGH];
    end
  end

endmodule

`default_nettype wire

// file: sim/ltp_timer_pair_props.sv
/* checker for the timer pair: bus handshake, irq clearing, clock-select copies.
   assumes: bound to ltp_timer_pair; one clock domain, clk_sys. */
`timescale 1ns/1ps
`default_nettype none
module ltp_timer_pair_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic vector_ack_a,
  input wire logic vector_ack_b,
  input wire logic overflow_irq_a,
  input wire logic overflow_irq_b,
  input wire logic irq,
  input wire logic reload_a_low_clock_sel,
  input wire logic reload_a_high_clock_sel,
  input wire logic reload_b_low_clock_sel,
  input wire logic reload_b_high_clock_sel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // answered clock-select write; the request is still held in the answer cycle
  logic sel_wr;
  assign sel_wr = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[9:2] == 8'h8E;
  a_answer_next: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("waitrequest not low one cycle after request");
  a_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  a_rdata_lane: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  a_reload_a_sel: assert property (
    sel_wr |=> {reload_a_high_clock_sel, reload_a_low_clock_sel} == $past(avs_writedata[5:4]))
    else $error("reload a clock selects do not follow write");
  a_reload_b_sel: assert property (
    sel_wr |=> {reload_b_high_clock_sel, reload_b_low_clock_sel} == $past(avs_writedata[7:6]))
    else $error("reload b clock selects do not follow write");
  a_status_clear: assert property (
    avs_read && !avs_waitrequest && avs_address[9:2] == 8'h91 |=> !irq)
    else $error("irq still high after status read");
  a_vector_a_clear: assert property (vector_ack_a |=> ##1 !overflow_irq_a)
    else $error("overflow irq a not cleared by vector ack");
  a_vector_b_clear: assert property (vector_ack_b |-> ##2 !overflow_irq_b)
    else $error("overflow irq b not cleared by vector ack");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_ovf_a: cover property ($rose(overflow_irq_a));
  c_irq: cover property ($rose(irq));
endmodule
bind ltp_timer_pair ltp_timer_pair_props u_props (.clk_sys(clk_sys), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .vector_ack_a(vector_ack_a), .vector_ack_b(vector_ack_b), .overflow_irq_a(overflow_irq_a),
  .overflow_irq_b(overflow_irq_b), .irq(irq), .reload_a_low_clock_sel(reload_a_low_clock_sel),
  .reload_a_high_clock_sel(reload_a_high_clock_sel),
  .reload_b_low_clock_sel(reload_b_low_clock_sel),
  .reload_b_high_clock_sel(reload_b_high_clock_sel));
`default_nettype wire

// file: sim/ltp_pin_model.sv
/* model of the external count, clock and gate pins.
   assumes: tasks are called from the bench; pins change just after clk_sys rises. */
`timescale 1ns/1ps
`default_nettype none
module ltp_pin_model #(
  parameter int HOLD = 3
) (
  input wire logic clk_sys,
  output logic count_pin_a,
  output logic count_pin_b,
  output logic ext_clock_pin,
  output logic gate_input_a,
  output logic gate_input_b
);
  // count and clock pins idle high so a release gives no spurious falling edge; gate pins idle low
  initial
  begin
    count_pin_a = 1'b1;
    count_pin_b = 1'b1;
    ext_clock_pin = 1'b1;
    gate_input_a = 1'b0;
    gate_input_b = 1'b0;
  end
  // each level stands HOLD clocks, above the two-clock sampling minimum
  task automatic drive(input int sel, input logic v);
    @(posedge clk_sys);
    if (sel == 0) count_pin_a <= v;
    else if (sel == 1) count_pin_b <= v;
    else ext_clock_pin <= v;
    repeat (HOLD - 1) @(posedge clk_sys);
  endtask
  // n falling edges on pin a (0), pin b (1) or the external clock (2)
  task automatic pulses(input int sel, input int n);
    repeat (n)
    begin
      drive(sel, 1'b0);
      drive(sel, 1'b1);
    end
  endtask
  // gate a active for exactly n clock cycles
  task automatic gate_a_for(input int n);
    @(posedge clk_sys);
    gate_input_a <= 1'b1;
    repeat (n) @(posedge clk_sys);
    gate_input_a <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
/* self-checking bench of the legacy timer pair over its avalon-mm slave.
   assumes: design files and pin model compiled first; clk_sys 250 MHz. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_read = 1'b0, avs_write = 1'b0, vector_ack_a = 1'b0, vector_ack_b = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, overflow_irq_a, overflow_irq_b, irq, s_al, s_ah, s_bl, s_bh;
  logic count_pin_a, count_pin_b, ext_clock_pin, gate_input_a, gate_input_b;
  int fail_count = 0, n_checks = 0, cyc = 0;
  int dv[3] = '{12, 4, 48};
  always #2 clk_sys = ~clk_sys;
  ltp_timer_pair u_dut (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .count_pin_a(count_pin_a), .count_pin_b(count_pin_b), .ext_clock_pin(ext_clock_pin),
    .gate_input_a(gate_input_a), .gate_input_b(gate_input_b), .vector_ack_a(vector_ack_a),
    .vector_ack_b(vector_ack_b), .overflow_irq_a(overflow_irq_a),
    .overflow_irq_b(overflow_irq_b), .irq(irq), .reload_a_low_clock_sel(s_al),
    .reload_a_high_clock_sel(s_ah), .reload_b_low_clock_sel(s_bl),
    .reload_b_high_clock_sel(s_bh));
  ltp_pin_model u_pins (.clk_sys(clk_sys), .count_pin_a(count_pin_a),
    .count_pin_b(count_pin_b), .ext_clock_pin(ext_clock_pin),
    .gate_input_a(gate_input_a), .gate_input_b(gate_input_b));
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    avs_read <= ~wr;
    avs_write <= wr;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    if (k >= 50) check("bus answer", 32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(nm, {24'h000000, exp}, rd);
  endtask
  task automatic t_regs();
    rchk("clock_select reset", 8'h8E, 8'h00);
    rchk("unmapped read", 8'h00, 8'h00);
    bus(1'b1, 8'h8E, 8'hA0);
    rchk("clock_select rw", 8'h8E, 8'hA0);
    repeat (2) @(posedge clk_sys);
    check("reload sels", 32'({s_bh, s_bl, s_ah, s_al}), 32'hA);
    // low lane disabled: the write is answered but must not land
    @(posedge clk_sys);
    avs_byteenable <= 4'hE;
    bus(1'b1, 8'h8E, 8'h55);
    avs_byteenable <= 4'hF;
    rchk("byteenable off", 8'h8E, 8'hA0);
    $display("t_regs done");
  endtask
  // a from 0x1FFA with irq enabled, b from 0x1FFF with it disabled
  task automatic t_overflow();
    bus(1'b1, 8'h8E, 8'h0C);
    bus(1'b1, 8'h8C, 8'hFF);
    bus(1'b1, 8'h8A, 8'hFA);
    bus(1'b1, 8'h8D, 8'hFF);
    bus(1'b1, 8'h8B, 8'h1F);
    bus(1'b1, 8'h90, 8'h02);
    bus(1'b1, 8'h88, 8'h50);
    repeat (10) @(posedge clk_sys);
    rchk("both flags", 8'h88, 8'hF0);
    bus(1'b1, 8'h88, 8'hA0);
    check("irq a", 32'(overflow_irq_a), 32'h1);
    check("irq b", 32'(overflow_irq_b), 32'h0);
    check("irq masked", 32'(irq), 32'h0);
    rchk("a high after wrap", 8'h8C, 8'h00);
    bus(1'b1, 8'h92, 8'h03);
    repeat (2) @(posedge clk_sys);
    check("irq unmasked", 32'(irq), 32'h1);
    rchk("status", 8'h91, 8'h03);
    @(posedge clk_sys);
    vector_ack_a <= 1'b1;
    @(posedge clk_sys);
    vector_ack_a <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("irq a after vector", 32'(overflow_irq_a), 32'h0);
    rchk("flag a cleared", 8'h88, 8'h80);
    // enable b late: its flag is still up, then the vector clears it
    bus(1'b1, 8'h90, 8'h0A);
    repeat (2) @(posedge clk_sys);
    check("irq b enabled", 32'(overflow_irq_b), 32'h1);
    vector_ack_b <= 1'b1;
    @(posedge clk_sys);
    vector_ack_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("irq b after vector", 32'(overflow_irq_b), 32'h0);
    rchk("flag b cleared", 8'h88, 8'h00);
    bus(1'b1, 8'h90, 8'h00);
    $display("t_overflow done");
  endtask
  // gate active high on timer a, system clock
  task automatic t_gate();
    bus(1'b1, 8'h8E, 8'h04);
    bus(1'b1, 8'h8F, 8'h08);
    bus(1'b1, 8'h89, 8'h08);
    bus(1'b1, 8'h8A, 8'h00);
    bus(1'b1, 8'h8C, 8'h00);
    bus(1'b1, 8'h88, 8'h10);
    repeat (20) @(posedge clk_sys);
    rchk("gate closed", 8'h8A, 8'h00);
    u_pins.gate_a_for(10);
    repeat (4) @(posedge clk_sys);
    rchk("gate open 10", 8'h8A, 8'h0A);
    // mode 01 without gate: still running, but this block must hold the count
    bus(1'b1, 8'h89, 8'h01);
    repeat (8) @(posedge clk_sys);
    rchk("mode 01 holds", 8'h8A, 8'h0A);
    bus(1'b1, 8'h88, 8'h00);
    $display("t_gate done");
  endtask
  // both in counter mode; system clock select bits must be ignored
  task automatic t_counter();
    bus(1'b1, 8'h89, 8'h44);
    bus(1'b1, 8'h8E, 8'h0C);
    bus(1'b1, 8'h8A, 8'h00);
    bus(1'b1, 8'h8B, 8'h00);
    bus(1'b1, 8'h88, 8'h50);
    u_pins.pulses(0, 5);
    u_pins.pulses(1, 3);
    repeat (6) @(posedge clk_sys);
    rchk("pin a count", 8'h8A, 8'h05);
    rchk("pin b count", 8'h8B, 8'h03);
    bus(1'b1, 8'h88, 8'h00);
    bus(1'b1, 8'h89, 8'h00);
    $display("t_counter done");
  endtask
  // about ten prescaled ticks per setting; phase of the first tick is free
  task automatic t_prescale();
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h8E, 8'(i));
      bus(1'b1, 8'h8A, 8'h00);
      bus(1'b1, 8'h88, 8'h10);
      if (i == 3) u_pins.pulses(2, 80);
      else repeat (dv[i] * 10) @(posedge clk_sys);
      bus(1'b1, 8'h88, 8'h00);
      bus(1'b0, 8'h8A, 8'h00);
      check("prescale ticks", 32'(rd[4:0] >= 5'h09 && rd[4:0] <= 5'h0B), 32'h1);
    end
    $display("t_prescale done");
  endtask
  // run-away guard, well above the roughly 1500 cycles the tests need
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      fail_count++;
      finish_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_overflow();
    t_gate();
    t_counter();
    t_prescale();
    finish_test();
  end
endmodule
`default_nettype wire
